// ### hdl/acsr_setup_regs.sv
// Purpose: Setup 0/1 reference and coding registers and the channel 3 input map.
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses, one clock.
// Notes:   Setups 2 and 3 live elsewhere and arrive as plain inputs.
`timescale 1ns/100ps
`default_nettype none
`include "acsr_consts.svh"

// What this block does
// - The channel 3 negative-input code routes input 0..4, the positive or the negative reference, and resets to input 1.
// - Each setup has its own 16-bit register holding reference and coding choices.
// - Bit 12 of a setup register picks unipolar (0) or offset binary (1) results.
// - Setup 0 sits at index 0x20 and resets to 0x1020.
// - Bits 5:4 pick external (00), internal (10) or supply-difference (11) reference, reset 10.
// - Reserved setup bits 15:13, 11:6 and 3:0 are read-only and software writes them as zero.
// - Setup 1 sits at index 0x21 with the same layout and reset value as setup 0.
// - A conversion uses the setup chosen by the active channel's 2-bit setup field.
module acsr_setup_regs (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Setups held outside this block
    input wire logic [15:0] setup2_cfg_i,
    input wire logic [15:0] setup3_cfg_i,
    // Channel 3 routing
    output logic ch3_enable_o,
    output logic [4:0] ch3_pos_select_o,
    output logic [6:0] ch3_neg_route_o,
    // Setup applied to channel 3 conversions
    output logic [1:0] ch3_setup_choice_o,
    output logic ch3_coding_o,
    output logic [1:0] ch3_reference_o
);

    logic ack_q;
    logic [31:0] rdata_q;
    logic req;
    logic wr_pulse;
    logic [5:0] word_idx;
    logic hit_setup0;
    logic hit_setup1;
    logic hit_chmap;
    logic [15:0] setup_cfg [0:`ACSR_NUM_SETUPS-1];
    logic [15:0] channel3_input_map;
    logic [15:0] rd_mux;
    logic [6:0] route_d;
    logic [6:0] route_q;
    logic en_q;
    logic [4:0] pos_q;
    logic [1:0] sel_q;
    logic coding_q;
    logic [1:0] ref_q;
    logic [15:0] active_cfg;
    logic [1:0] active_ref_code;
    acsr_pkg::acsr_ref_type ref_d;

    // Bus request decode; registers are word aligned so low address bits are ignored
    assign req = wb_cyc_i & wb_stb_i;
    assign word_idx = wb_adr_i[7:2];
    // Write lands at the edge where the master sees ack, not before
    assign wr_pulse = req & wb_we_i & ack_q;

    // Address decode
    always_comb begin
        hit_setup0 = 1'b0;
        hit_setup1 = 1'b0;
        hit_chmap = 1'b0;
        if (word_idx == `ACSR_IDX_SETUP0) begin
            hit_setup0 = 1'b1;
        end else if (word_idx == `ACSR_IDX_SETUP1) begin
            hit_setup1 = 1'b1;
        end else if (word_idx == `ACSR_IDX_CH3MAP) begin
            hit_chmap = 1'b1;
        end
    end

    // One register per setup, same layout and reset for both
    genvar gi;
    generate
        for (gi = 0; gi < `ACSR_NUM_SETUPS; gi = gi + 1) begin : g_setup
            logic hit;
            assign hit = (gi == 0) ? hit_setup0 : hit_setup1;
            acsr_reg16 #(
                .RESET_VAL(`ACSR_SETUP_RST),
                .WMASK(`ACSR_SETUP_WMASK)
            ) u_setup (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .wr_i(wr_pulse & hit),
                .sel_i(wb_sel_i[1:0]),
                .data_i(wb_dat_i[15:0]),
                .value_o(setup_cfg[gi])
            );
        end
    endgenerate

    // Channel 3 map: reserved bits 14 and 11:10 stay zero
    acsr_reg16 #(
        .RESET_VAL(`ACSR_CHMAP_RST),
        .WMASK(`ACSR_CHMAP_WMASK)
    ) u_ch3_map (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_pulse & hit_chmap),
        .sel_i(wb_sel_i[1:0]),
        .data_i(wb_dat_i[15:0]),
        .value_o(channel3_input_map)
    );

    // Read mux; unmapped words read as zero and still get an ack
    always_comb begin
        rd_mux = 16'h0000;
        if (hit_setup0) begin
            rd_mux = setup_cfg[0];
        end else if (hit_setup1) begin
            rd_mux = setup_cfg[1];
        end else if (hit_chmap) begin
            rd_mux = channel3_input_map;
        end
    end

    // Ack one cycle after the request, dropped the cycle after it was given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read data captured with the ack so it is stable while ack is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h00000000;
        end else if (req & ~ack_q) begin
            rdata_q <= {16'h0000, rd_mux};
        end
    end

    // Negative input decode; unlisted codes leave the input unconnected
    always_comb begin
        route_d = 7'h00;
        if (channel3_input_map[`ACSR_NEG_HI:`ACSR_NEG_LO] <= `ACSR_IN_LAST) begin
            route_d[channel3_input_map[2:0]] = 1'b1;
        end else if (channel3_input_map[`ACSR_NEG_HI:`ACSR_NEG_LO] == `ACSR_IN_REFP) begin
            route_d[`ACSR_ROUTE_REFP] = 1'b1;
        end else if (channel3_input_map[`ACSR_NEG_HI:`ACSR_NEG_LO] == `ACSR_IN_REFN) begin
            route_d[`ACSR_ROUTE_REFN] = 1'b1;
        end
    end

    // Pick the setup named by the channel's setup field
    always_comb begin
        case (channel3_input_map[`ACSR_SETUP_SEL_HI:`ACSR_SETUP_SEL_LO])
            2'b00: active_cfg = setup_cfg[0];
            2'b01: active_cfg = setup_cfg[1];
            2'b10: active_cfg = setup2_cfg_i;
            default: active_cfg = setup3_cfg_i;
        endcase
    end

    assign active_ref_code = active_cfg[`ACSR_REF_HI:`ACSR_REF_LO];

    // Reference decode; the undefined code falls back to the external source
    always_comb begin
        case (active_ref_code)
            2'b10: ref_d = acsr_pkg::ACSR_REF_INTERNAL;
            2'b11: ref_d = acsr_pkg::ACSR_REF_SUPPLY;
            default: ref_d = acsr_pkg::ACSR_REF_EXTERNAL;
        endcase
    end

    // Routing outputs registered so the analog switches see no decode glitches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_q <= 7'h02;
            en_q <= 1'b0;
            pos_q <= 5'h00;
        end else begin
            route_q <= route_d;
            en_q <= channel3_input_map[`ACSR_CH_EN_BIT];
            pos_q <= channel3_input_map[`ACSR_POS_HI:`ACSR_POS_LO];
        end
    end

    // Active setup outputs; internal reference power is software's job elsewhere
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_q <= 2'h0;
            coding_q <= 1'b1;
            ref_q <= 2'h2;
        end else begin
            sel_q <= channel3_input_map[`ACSR_SETUP_SEL_HI:`ACSR_SETUP_SEL_LO];
            coding_q <= active_cfg[`ACSR_CODING_BIT];
            ref_q <= ref_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign ch3_enable_o = en_q;
    assign ch3_pos_select_o = pos_q;
    assign ch3_neg_route_o = route_q;
    assign ch3_setup_choice_o = sel_q;
    assign ch3_coding_o = coding_q;
    assign ch3_reference_o = ref_q;

endmodule : acsr_setup_regs

`default_nettype wire

// ### hdl/acsr_consts.svh
// Purpose: Offsets, field positions, reset values and codes of the setup register bank.
// Assumes: Register indices are word indices; the byte address is four times the index.
// Notes:   Definitions only.
`ifndef ACSR_CONSTS_SVH
`define ACSR_CONSTS_SVH

// Register indices (byte address = index * 4)
`define ACSR_IDX_SETUP0 6'h20
`define ACSR_IDX_SETUP1 6'h21
`define ACSR_IDX_CH3MAP 6'h10

// Reset values and writable-bit masks
`define ACSR_SETUP_RST 16'h1020
`define ACSR_SETUP_WMASK 16'h1030
`define ACSR_CHMAP_RST 16'h0001
`define ACSR_CHMAP_WMASK 16'hB3FF

// Setup register fields
`define ACSR_CODING_BIT 12
`define ACSR_REF_HI 5
`define ACSR_REF_LO 4

// Channel map fields
`define ACSR_CH_EN_BIT 15
`define ACSR_SETUP_SEL_HI 13
`define ACSR_SETUP_SEL_LO 12
`define ACSR_POS_HI 9
`define ACSR_POS_LO 5
`define ACSR_NEG_HI 4
`define ACSR_NEG_LO 0

// Input select codes
`define ACSR_IN_LAST 5'h04
`define ACSR_IN_REFP 5'h15
`define ACSR_IN_REFN 5'h16

// Number of setups held here and routing vector width
`define ACSR_NUM_SETUPS 2
`define ACSR_ROUTE_W 7
`define ACSR_ROUTE_REFP 5
`define ACSR_ROUTE_REFN 6

`endif

// ### hdl/acsr_pkg.sv
// Purpose: Types shared by the setup register bank.
// Assumes: Constants come from acsr_consts.svh.
// Notes:   Holds types only.
package acsr_pkg;

    // Reference source as seen by the converter
    typedef enum logic [1:0] {
        ACSR_REF_EXTERNAL = 2'b00,
        ACSR_REF_INTERNAL = 2'b10,
        ACSR_REF_SUPPLY = 2'b11
    } acsr_ref_type;

    // Output coding of results
    typedef enum logic {
        ACSR_CODE_UNIPOLAR = 1'b0,
        ACSR_CODE_OFFSET_BIN = 1'b1
    } acsr_coding_type;

endpackage : acsr_pkg

// ### hdl/acsr_reg16.sv
// Purpose: One 16-bit software register with byte-lane writes and read-only bits.
// Assumes: Write strobe is a single-cycle pulse from the bus slave.
// Notes:   Bits outside WMASK hold their reset value and ignore writes.
`timescale 1ns/100ps
`default_nettype none

module acsr_reg16 #(
    parameter logic [15:0] RESET_VAL = 16'h0000,
    parameter logic [15:0] WMASK = 16'hFFFF
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Write port
    input wire logic wr_i,
    input wire logic [1:0] sel_i,
    input wire logic [15:0] data_i,
    // Stored value
    output logic [15:0] value_o
);

    logic [15:0] value_q;
    logic [15:0] lane_mask;

    // Writable bits in the enabled byte lanes
    assign lane_mask = WMASK & {{8{sel_i[1]}}, {8{sel_i[0]}}};

    // Read-only bits keep their reset value forever
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            value_q <= RESET_VAL;
        end else if (wr_i) begin
            value_q <= (value_q & ~lane_mask) | (data_i & lane_mask);
        end
    end

    assign value_o = value_q;

endmodule : acsr_reg16

`default_nettype wire

// ### bench/acsr_setup_regs_asserts.sv
// Purpose: Port-level checks of the setup register bank.
// Assumes: Setups 2/3 inputs change rarely; derived outputs lag by one clock.
// Notes:   Bound to the top module at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
`include "acsr_consts.svh"
module acsr_setup_regs_asserts (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Setups held outside
    input wire logic [15:0] setup2_cfg_i,
    input wire logic [15:0] setup3_cfg_i,
    // Channel 3 outputs
    input wire logic ch3_enable_o,
    input wire logic [4:0] ch3_pos_select_o,
    input wire logic [6:0] ch3_neg_route_o,
    input wire logic [1:0] ch3_setup_choice_o,
    input wire logic ch3_coding_o,
    input wire logic [1:0] ch3_reference_o
);
    // Undefined code 01 falls back to the external reference
    function automatic logic [1:0] ref_of(input logic [15:0] c);
        return (c[5:4] == 2'b01) ? 2'b00 : c[5:4];
    endfunction : ref_of
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_rd_upper;
        wb_ack_o |-> wb_dat_o[31:16] == 16'h0000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper half set");
    // Setup words sit at 0x80 and 0x84
    property p_rsv_ro;
        wb_ack_o && !wb_we_i && wb_adr_i[7:3] == 5'h10
            |-> (wb_dat_o[15:0] & ~`ACSR_SETUP_WMASK) == 16'h0000;
    endproperty
    a_rsv_ro: assert property (p_rsv_ro) else $error("reserved bit set");
    property p_neg_onehot;
        $onehot0(ch3_neg_route_o);
    endproperty
    a_neg_onehot: assert property (p_neg_onehot) else $error("route not one-hot");
    property p_rst_val;
        $past(rst_i) |-> ch3_neg_route_o == 7'h02 && ch3_reference_o == 2'b10 && ch3_coding_o;
    endproperty
    a_rst_val: assert property (p_rst_val) else $error("bad reset outputs");
    property p_setup2;
        ch3_setup_choice_o == 2'h2 && $stable(setup2_cfg_i)
            |-> ch3_coding_o == setup2_cfg_i[12] && ch3_reference_o == ref_of(setup2_cfg_i);
    endproperty
    a_setup2: assert property (p_setup2) else $error("setup 2 not applied");
    property p_setup3;
        ch3_setup_choice_o == 2'h3 && $stable(setup3_cfg_i)
            |-> ch3_coding_o == setup3_cfg_i[12] && ch3_reference_o == ref_of(setup3_cfg_i);
    endproperty
    a_setup3: assert property (p_setup3) else $error("setup 3 not applied");
    // Main scenarios
    c_write: cover property (wb_ack_o && wb_we_i);
    c_sel2: cover property (ch3_setup_choice_o == 2'h2);
    c_refp: cover property (ch3_neg_route_o == 7'h20);
endmodule : acsr_setup_regs_asserts
bind acsr_setup_regs acsr_setup_regs_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .setup2_cfg_i(setup2_cfg_i), .setup3_cfg_i(setup3_cfg_i), .ch3_enable_o(ch3_enable_o),
    .ch3_pos_select_o(ch3_pos_select_o), .ch3_neg_route_o(ch3_neg_route_o),
    .ch3_setup_choice_o(ch3_setup_choice_o), .ch3_coding_o(ch3_coding_o),
    .ch3_reference_o(ch3_reference_o));
`default_nettype wire

// ### bench/acsr_setup_regs_tb_top.sv
// Purpose: Self-checking bench of the setup register bank.
// Assumes: Wishbone answers in one cycle; derived outputs lag one clock.
// Notes:   Reset values first, then table rows, routing and mid-run reset.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module acsr_setup_regs_tb_top;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ch3_enable_o, ch3_coding_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [15:0] setup2_cfg_i, setup3_cfg_i;
    logic [4:0] ch3_pos_select_o;
    logic [6:0] ch3_neg_route_o;
    logic [1:0] ch3_setup_choice_o, ch3_reference_o;
    int error_cnt = 0;
    int total_checks = 0;
    // Rows: address, write data, lanes, read-back
    logic [7:0] t_adr [6] = '{8'h80, 8'h80, 8'h84, 8'h40, 8'h40, 8'hFC};
    logic [15:0] t_wd [6] = '{16'hFFFF, 16'h0000, 16'h0010, 16'hFFFF, 16'h4C00, 16'hFFFF};
    logic [3:0] t_sel [6] = '{4'h3, 4'h3, 4'h1, 4'h3, 4'h2, 4'h3};
    logic [15:0] t_rd [6] = '{16'h1030, 16'h0000, 16'h1010, 16'hB3FF, 16'h00FF, 16'h0000};
    // Coding and reference per setup choice, as left by the rows and the setup 2/3 inputs
    logic [2:0] exp_cr [4] = '{3'b000, 3'b100, 3'b011, 3'b110};
    logic [4:0] codes [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h15, 5'h16, 5'h07};
    logic [6:0] routes [8] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h00};
    acsr_setup_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .setup2_cfg_i(setup2_cfg_i), .setup3_cfg_i(setup3_cfg_i), .ch3_enable_o(ch3_enable_o),
        .ch3_pos_select_o(ch3_pos_select_o), .ch3_neg_route_o(ch3_neg_route_o),
        .ch3_setup_choice_o(ch3_setup_choice_o), .ch3_coding_o(ch3_coding_o),
        .ch3_reference_o(ch3_reference_o));
    // 25 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // One classic cycle; entered just after an edge, leaves one idle cycle
    task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {16'h0000, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    // Hang guard, far beyond the hundred or so cycles needed
    initial begin
        #80000;
        error_cnt++;
        final_report();
    end
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} <= 4'h8;
        {wb_adr_i, wb_sel_i, wb_dat_i} <= '0;
        setup2_cfg_i <= 16'h0030;
        // Internal reference picked here; powering it stays software's job
        setup3_cfg_i <= 16'h1020;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK(ch3_neg_route_o, 7'h02)
        `CHK({ch3_coding_o, ch3_reference_o}, 3'b110)
        `CHK({ch3_enable_o, ch3_pos_select_o, ch3_setup_choice_o}, 8'h00)
        wb(1'b0, 8'h80, 16'h0000, 4'h3, rd);
        `CHK(rd, 32'h0000_1020)
        wb(1'b0, 8'h84, 16'h0000, 4'h3, rd);
        `CHK(rd, 32'h0000_1020)
        wb(1'b0, 8'h40, 16'h0000, 4'h3, rd);
        `CHK(rd, 32'h0000_0001)
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, t_adr[i], t_wd[i], t_sel[i], rd);
            wb(1'b0, t_adr[i], 16'h0000, 4'h3, rd);
            `CHK(rd, {16'h0000, t_rd[i]})
        end
        // Every routing code, walking through all four setup choices
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, 8'h40, {2'b10, i[1:0], 2'b00, 5'h03, codes[i]}, 4'h3, rd);
            @(posedge clk_i);
            `CHK(ch3_neg_route_o, routes[i])
            `CHK(ch3_setup_choice_o, i[1:0])
            `CHK(ch3_coding_o, exp_cr[i % 4][2])
            `CHK(ch3_reference_o, exp_cr[i % 4][1:0])
            `CHK({ch3_enable_o, ch3_pos_select_o}, 6'h23)
        end
        // Setup 3 changed while it is selected: applied one edge later
        setup3_cfg_i <= 16'h0030;
        repeat (2) @(posedge clk_i);
        `CHK({ch3_coding_o, ch3_reference_o}, 3'b011)
        // Reset in mid-run restores the setup word and the routing outputs
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK(ch3_neg_route_o, 7'h02)
        `CHK({ch3_coding_o, ch3_reference_o}, 3'b110)
        `CHK({ch3_enable_o, ch3_pos_select_o, ch3_setup_choice_o}, 8'h00)
        wb(1'b0, 8'h80, 16'h0000, 4'h3, rd);
        `CHK(rd, 32'h0000_1020)
        final_report();
    end
endmodule : acsr_setup_regs_tb_top
`default_nettype wire
